// >>> dv/fs_link_asserts.sv
// concurrent checks on the link between the two flash ends
`timescale 1ns/1ps
module fs_link_asserts
  import fs_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        req,
  input wire fs_op_e      op,
  input wire logic [15:0] addr,
  input wire logic        swap_en,
  input wire logic        irq_ack,
  input wire logic [1:0]  irq_level,
  input wire logic        ack,
  input wire logic        refused,
  input wire logic        busy,
  input wire logic        irq_req,
  input wire logic [1:0]  irq_prio
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  property p_ack_answer;
    $rose(req) |=> ack ##1 !ack;
  endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("link answer not one cycle after request");

  property p_req_drop;
    ack |=> !req;
  endproperty
  a_req_drop: assert property (p_req_drop)
    else $error("request still high after answer");

  property p_prog_time;
    ack && !refused && op == FS_OP_PROG |=> busy [*8] ##1 busy ##1 !busy;
  endproperty
  a_prog_time: assert property (p_prog_time)
    else $error("program busy span wrong");

  property p_irq_set;
    $fell(busy) |-> ##[0:1] irq_req;
  endproperty
  a_irq_set: assert property (p_irq_set)
    else $error("no interrupt after completion");

  property p_irq_hold;
    irq_req && !irq_ack |=> irq_req;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt dropped without acknowledge");

  property p_irq_clear;
    irq_ack && !busy && !$past(busy) |=> !irq_req;
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("interrupt not cleared by acknowledge");

  property p_prio;
    $rose(irq_req) |-> irq_prio == irq_level;
  endproperty
  a_prio: assert property (p_prio)
    else $error("interrupt priority not the level field");

  property p_swap_stable;
    busy && $past(busy) |-> $stable(swap_en);
  endproperty
  a_swap_stable: assert property (p_swap_stable)
    else $error("swap changed during write");

  property p_upper_swap;
    req && (op == FS_OP_CERASE || (addr[15] && op inside {FS_OP_PROG, FS_OP_SERASE}))
      |-> swap_en;
  endproperty
  a_upper_swap: assert property (p_upper_swap)
    else $error("upper bank modify without swap");
endmodule : fs_link_asserts

// >>> dv/tb_top.sv
// self-checking bench joining both flash ends over the link
`timescale 1ns/1ps
module tb_top;
  import fs_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_req = 1'b0;
  logic        ext_we = 1'b0;
  logic [15:0] ext_addr = 16'h0;
  logic [7:0]  ext_wdata = 8'h00;
  logic        ext_ack;
  logic [7:0]  ext_rdata;
  logic        ext_err;
  logic [31:0] rd;
  logic        er;
  logic [1:0]  st;
  logic [8:0]  pin_res;
  int          mismatches = 0;
  int          num_checks = 0;

  always #2 clk = ~clk;

  fs_if link ();
  fs_flash_dev fs_flash_dev_i (.clk(clk), .srst(srst), .bus(link), .ext_req(ext_req),
    .ext_we(ext_we), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_ack(ext_ack),
    .ext_rdata(ext_rdata), .ext_err(ext_err));
  fs_flash_host fs_flash_host_i (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(link));
  fs_link_asserts fs_link_asserts_i (.clk(clk), .srst(srst), .req(link.req), .op(link.op),
    .addr(link.addr), .swap_en(link.swap_en), .irq_ack(link.irq_ack),
    .irq_level(link.irq_level), .ack(link.ack), .refused(link.refused), .busy(link.busy),
    .irq_req(link.irq_req), .irq_prio(link.irq_prio));

  task automatic end_of_test;
    if (mismatches == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // issue one operation and wait for done or error, then clear both
  task automatic run_op(input fs_op_e op, input logic [15:0] a, input logic [7:0] d);
    apb(1'b1, REG_ADDR, {16'h0, a});
    apb(1'b1, REG_WDATA, {24'h0, d});
    apb(1'b1, REG_CTRL, {28'h0, op, 1'b1});
    rd = 32'h0;
    for (int i = 0; i < 400 && rd[10:9] == 2'b00; i++) apb(1'b0, REG_STAT, 32'h0);
    st = rd[10:9];
    apb(1'b1, REG_STAT, 32'h600);
  endtask : run_op

  task automatic read_chk(input string n, input fs_op_e op, input logic [15:0] a,
                          input logic [7:0] exp);
    run_op(op, a, 8'h00);
    apb(1'b0, REG_STAT, 32'h0);
    chk(n, {24'h0, exp}, {24'h0, rd[7:0]});
  endtask : read_chk

  // pin access; result is {error, data}
  task automatic pin(input logic w, input logic [15:0] a, input logic [7:0] d);
    ext_we <= w;
    ext_addr <= a;
    ext_wdata <= d;
    ext_req <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      if (ext_ack === 1'b1) break;
    end
    pin_res = {ext_err, ext_rdata};
    ext_req <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : pin

  task automatic t_regs;
    apb(1'b0, REG_CFG, 32'h0);
    chk("cfg_reset", 32'h0000000c, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
  endtask : t_regs

  task automatic t_erase;
    run_op(FS_OP_CERASE, 16'h0000, 8'h00);
    chk("erase_no_swap", 32'h2, {30'h0, st});
    apb(1'b1, REG_CFG, 32'h0d);
    apb(1'b0, REG_CFG, 32'h0);
    chk("cfg_swap", 32'h1d, rd);
    run_op(FS_OP_CERASE, 16'h0000, 8'h00);
    chk("erase_done", 32'h1, {30'h0, st});
    read_chk("erased", FS_OP_READ, 16'h8000, ERASED);
  endtask : t_erase

  task automatic t_vectors;
    run_op(FS_OP_PROG, VEC_HI_ADDR, 8'h5a);
    run_op(FS_OP_PROG, 16'h00cc, 8'h3c);
    read_chk("vec_swapped", FS_OP_VEC, VEC_HI_ADDR, 8'h3c);
    apb(1'b1, REG_CFG, 32'h0c);
    read_chk("vec_plain", FS_OP_VEC, VEC_HI_ADDR, 8'h5a);
    apb(1'b1, REG_CFG, 32'h0d);
    run_op(FS_OP_PROG, VEC_HI_ADDR, 8'h0f);
    read_chk("prog_and", FS_OP_READ, VEC_HI_ADDR, 8'h0a);
  endtask : t_vectors

  // swap request made during a program must wait for the end, then sector erase
  task automatic t_swap_hold;
    apb(1'b1, REG_ADDR, 32'h20);
    apb(1'b1, REG_CTRL, {28'h0, FS_OP_PROG, 1'b1});
    apb(1'b1, REG_CFG, 32'h0c);
    apb(1'b0, REG_CFG, 32'h0);
    chk("swap_held", 32'h1c, rd);
    apb(1'b0, REG_STAT, 32'h0);
    chk("busy_unsafe", 32'h0, {31'h0, rd[STAT_SAFE]});
    for (int i = 0; i < 50 && rd[STAT_DONE] !== 1'b1; i++) apb(1'b0, REG_STAT, 32'h0);
    chk("idle_safe", 32'h3, {30'h0, rd[STAT_SAFE], rd[STAT_DONE]});
    apb(1'b1, REG_STAT, 32'h600);
    apb(1'b0, REG_CFG, 32'h0);
    chk("swap_released", 32'h0c, rd);
    apb(1'b1, REG_CFG, 32'h0d);
    run_op(FS_OP_SERASE, 16'h8000, 8'h00);
    chk("serase_done", 32'h1, {30'h0, st});
    read_chk("serase_bank", FS_OP_READ, VEC_HI_ADDR, ERASED);
    read_chk("serase_other", FS_OP_READ, 16'h00cc, 8'h3c);
  endtask : t_swap_hold

  task automatic t_irq;
    apb(1'b1, REG_CFG, 32'h0b);
    run_op(FS_OP_PROG, 16'h0010, 8'h77);
    rd = 32'h800;
    for (int i = 0; i < 50 && rd[STAT_IRQ] !== 1'b0; i++) apb(1'b0, REG_STAT, 32'h0);
    chk("irq_served", 32'h0, {31'h0, rd[STAT_IRQ]});
    chk("irq_prio", 32'h2, {30'h0, link.irq_prio});
    apb(1'b0, REG_VEC, 32'h0);
    chk("vec_fetch", 32'h3cff, {16'h0, rd[15:0]});
    apb(1'b1, REG_CFG, 32'h0d);
  endtask : t_irq

  task automatic t_lock;
    pin(1'b1, 16'h0030, 8'h12);
    repeat (20) @(posedge clk);
    pin(1'b0, 16'h0030, 8'h00);
    chk("pin_read", 32'h012, {23'h0, pin_res});
    run_op(FS_OP_PROG, 16'hfffc, PROT_CODE);
    pin(1'b0, 16'h0030, 8'h00);
    chk("pin_locked", 32'h100, {23'h0, pin_res});
    run_op(FS_OP_PROG, 16'h0040, 8'h00);
    chk("prog_locked", 32'h2, {30'h0, st});
    run_op(FS_OP_SERASE, 16'h0000, 8'h00);
    chk("serase_locked", 32'h2, {30'h0, st});
    run_op(FS_OP_CERASE, 16'h0000, 8'h00);
    chk("unlock_erase", 32'h1, {30'h0, st});
    pin(1'b0, 16'h0030, 8'h00);
    chk("pin_unlocked", 32'h0ff, {23'h0, pin_res});
  endtask : t_lock

  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    t_regs;
    t_erase;
    t_vectors;
    t_swap_hold;
    t_irq;
    t_lock;
    end_of_test;
  end

  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    end_of_test;
  end
endmodule : tb_top

// >>> rtl/fs_flash_dev.sv
// device end: two-bank flash array with vector swap, security lock and done interrupt
`timescale 1ns/1ps
// Notes on behaviour
// - no read of a bank under modify
// - swap on: vectors come from lower sector
// - software sets swap before upper-bank modify
// - software copies vectors before setting swap
// - swap changes only outside a write
// - flash interrupt masked around swap change
// - interrupt routine issues no flash write
// - write and erase routines run one by one
// - no mode change during write or erase
// - completion raises interrupt with level field
// - code 01 at fffc blocks pin access
// - lock holds until full chip erase
// - write protection code last
// - flash-resident code polls data-polling flag
// - toggle flag valid for ram-resident code
// - data-polling bit read from last address
module fs_flash_dev
  import fs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  fs_if.dev                bus,
  input  wire logic        ext_req,
  input  wire logic        ext_we,
  input  wire logic [15:0] ext_addr,
  input  wire logic [7:0]  ext_wdata,
  output logic             ext_ack,
  output logic [7:0]       ext_rdata,
  output logic             ext_err
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ERASE} fs_dst_e;
  localparam int EXT_W = 26;

  logic [7:0]       mem [0:ARR_SIZE-1];
  fs_dst_e          st_q;
  logic [CNT_W-1:0] cnt_q;
  logic             busy_q;
  logic             bank_q;
  logic             chip_q;
  logic             prog_q;
  logic [IDX_W-1:0] last_idx_q;
  logic [7:0]       last_dat_q;
  logic             tog_q;
  logic             ack_q;
  logic             ref_q;
  logic [7:0]       rdata_q;
  logic             irq_q;
  logic [1:0]       prio_q;
  logic [EXT_W-1:0] ext_s1_q;
  logic [EXT_W-1:0] ext_s2_q;
  logic             ext_prev_q;
  logic             ext_pend_q;
  logic             ext_ack_q;
  logic             ext_err_q;
  logic [7:0]       ext_rdata_q;
  fs_op_e           a_op;

  // pin-side request, only the second sync stage is looked at
  wire        ext_rise = ext_s2_q[EXT_W-1] & ~ext_prev_q;
  wire        x_we     = ext_s2_q[24];
  wire [15:0] x_addr   = ext_s2_q[23:8];
  wire [7:0]  x_wdata  = ext_s2_q[7:0];

  // cpu request is new until it has been answered once
  wire        cpu_new  = bus.req & ~ack_q;
  wire        sel_ext  = ext_pend_q & ~cpu_new;
  wire        acc      = cpu_new | sel_ext;
  assign a_op = sel_ext ? (x_we ? FS_OP_PROG : FS_OP_READ) : bus.op;
  wire [15:0] a_addr   = sel_ext ? x_addr : bus.addr;
  wire [7:0]  a_wdata  = sel_ext ? x_wdata : bus.wdata;

  // vector fetch redirected to lower bank with swap on
  wire             swap_vec = (a_op == FS_OP_VEC) & bus.swap_en;
  wire [IDX_W-1:0] idx      = {a_addr[15] & ~swap_vec, a_addr[7:0]};

  wire is_mod  = (a_op == FS_OP_PROG) | (a_op == FS_OP_SERASE) | (a_op == FS_OP_CERASE);
  wire is_lock = (a_op == FS_OP_PROG) | (a_op == FS_OP_SERASE);
  // lock state read from the array itself
  wire prot    = (mem[PROT_IDX] == PROT_CODE);
  wire ref_ext  = sel_ext & prot;
  // of the modify commands only a chip erase passes the lock
  wire ref_lock = prot & is_lock;
  // modify commands are refused while an automatic operation runs; reads still pass
  wire ref_any  = ref_ext | ref_lock | (is_mod & busy_q);
  wire start    = acc & is_mod & ~ref_any;
  wire do_read  = acc & ~is_mod & ~ref_any;

  // a busy bank answers with status instead of data
  wire tgt_busy = busy_q & (chip_q | (idx[IDX_W-1] == bank_q));
  // bit 7 is the inverse of the pending data until done
  // bit 6 flips on every status read
  wire [7:0] stat_byte = {~last_dat_q[7], tog_q, 6'h00};
  wire [7:0] rd_val    = tgt_busy ? stat_byte : mem[idx];
  wire       stat_rd   = do_read & tgt_busy;

  wire cnt_zero = (cnt_q == '0);
  wire in_wait  = (st_q == ST_WAIT);
  wire in_erase = (st_q == ST_ERASE);
  wire done     = cnt_zero & ((in_wait & prog_q) | in_erase);
  wire [IDX_W-1:0] walk_idx = chip_q ? cnt_q[IDX_W-1:0] : {bank_q, cnt_q[7:0]};

  // programming can only clear bits; erasing sets a whole sector
  wire             mem_we   = (in_wait & prog_q & cnt_zero) | in_erase;
  wire [IDX_W-1:0] mem_widx = in_erase ? walk_idx : last_idx_q;
  wire [7:0]       mem_wdat = in_erase ? ERASED : (mem[last_idx_q] & last_dat_q);

  // array content is kept across reset
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_widx] <= mem_wdat;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ext_s1_q   <= '0;
      ext_s2_q   <= '0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_s1_q   <= {ext_req, ext_we, ext_addr, ext_wdata};
      ext_s2_q   <= ext_s1_q;
      ext_prev_q <= ext_s2_q[EXT_W-1];
    end
  end

  // operation sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q       <= ST_IDLE;
      cnt_q      <= '0;
      busy_q     <= 1'b0;
      bank_q     <= 1'b0;
      chip_q     <= 1'b0;
      prog_q     <= 1'b0;
      last_idx_q <= '0;
      last_dat_q <= '0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (start) begin
            st_q       <= ST_WAIT;
            busy_q     <= 1'b1;
            bank_q     <= idx[IDX_W-1];
            chip_q     <= (a_op == FS_OP_CERASE);
            prog_q     <= (a_op == FS_OP_PROG);
            last_idx_q <= idx;
            last_dat_q <= (a_op == FS_OP_PROG) ? a_wdata : ERASED;
            cnt_q      <= (a_op == FS_OP_PROG) ? CNT_W'(PROG_CYC - 1) : CNT_W'(ERASE_CYC - 1);
          end
        end
        ST_WAIT: begin
          if (!cnt_zero) begin
            cnt_q <= cnt_q - 1'b1;
          end else if (prog_q) begin
            st_q   <= ST_IDLE;
            busy_q <= 1'b0;
          end else begin
            st_q  <= ST_ERASE;
            cnt_q <= chip_q ? CNT_W'(ARR_SIZE - 1) : CNT_W'(SECT_SIZE - 1);
          end
        end
        ST_ERASE: begin
          if (!cnt_zero) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            st_q   <= ST_IDLE;
            busy_q <= 1'b0;
          end
        end
        default: begin
          st_q   <= ST_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // answers to the cpu end and to the pins
  always_ff @(posedge clk) begin
    if (srst) begin
      ack_q       <= 1'b0;
      ref_q       <= 1'b0;
      rdata_q     <= '0;
      tog_q       <= 1'b0;
      ext_pend_q  <= 1'b0;
      ext_ack_q   <= 1'b0;
      ext_err_q   <= 1'b0;
      ext_rdata_q <= '0;
    end else begin
      ack_q      <= cpu_new;
      ext_ack_q  <= sel_ext;
      ext_pend_q <= ext_rise | (ext_pend_q & ~sel_ext);
      if (cpu_new) begin
        ref_q   <= ref_any;
        rdata_q <= do_read ? rd_val : 8'h00;
      end
      if (sel_ext) begin
        ext_err_q   <= ref_any;
        ext_rdata_q <= do_read ? rd_val : 8'h00;
      end
      if (stat_rd) begin
        tog_q <= ~tog_q;
      end
    end
  end

  // sticky request, new completion wins over acknowledge
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_q  <= 1'b0;
      prio_q <= '0;
    end else begin
      irq_q <= done | (irq_q & ~bus.irq_ack);
      if (done) begin
        prio_q <= bus.irq_level;
      end
    end
  end

  assign bus.ack      = ack_q;
  assign bus.refused  = ref_q;
  assign bus.rdata    = rdata_q;
  assign bus.busy     = busy_q;
  assign bus.irq_req  = irq_q;
  assign bus.irq_prio = prio_q;
  assign ext_ack      = ext_ack_q;
  assign ext_err      = ext_err_q;
  assign ext_rdata    = ext_rdata_q;
endmodule : fs_flash_dev

// >>> rtl/fs_flash_host.sv
// cpu end: apb-programmed controller that drives flash cycles and serves the interrupt
`timescale 1ns/1ps
module fs_flash_host
  import fs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  fs_if.host               bus
);
  typedef enum logic [1:0] {HS_IDLE, HS_CMD, HS_POLL, HS_VEC} fs_hst_e;

  fs_hst_e     st_q;
  logic [15:0] addr_q;
  logic [7:0]  wdata_q;
  logic        swap_req_q;
  logic        swap_act_q;
  logic        irq_en_q;
  logic [1:0]  lvl_q;
  logic        done_q;
  logic        err_q;
  logic [7:0]  rd_q;
  logic [15:0] vec_q;
  logic        vec_lo_q;
  logic        idle_seen_q;
  logic [7:0]  exp_q;
  logic        req_q;
  fs_op_e      op_q;
  logic [15:0] a_q;
  logic        irq_ack_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  fs_op_e      new_op;
  logic [31:0] rmux;

  wire acc_new = psel & penable & ~pready_q;
  wire wr_fire = psel & penable & pready_q & pwrite;
  wire hit_ctrl = (paddr == REG_CTRL);
  wire hit_addr = (paddr == REG_ADDR);
  wire hit_wdat = (paddr == REG_WDATA);
  wire hit_stat = (paddr == REG_STAT);
  wire hit_cfg  = (paddr == REG_CFG);
  wire hit_vec  = (paddr == REG_VEC);
  wire mapped   = hit_ctrl | hit_addr | hit_wdat | hit_stat | hit_cfg | hit_vec;

  assign new_op = fs_op_e'(pwdata[CTRL_OP_LSB +: 3]);
  wire new_mod = (new_op == FS_OP_PROG) | (new_op == FS_OP_SERASE) | (new_op == FS_OP_CERASE);
  wire go      = wr_fire & hit_ctrl & pwdata[CTRL_GO];
  wire idle    = (st_q == HS_IDLE);
  // upper-bank modify refused with swap off
  wire need_swap = new_mod & (addr_q[15] | (new_op == FS_OP_CERASE)) & ~swap_act_q;
  wire go_ok   = go & idle & ~(new_mod & bus.busy) & ~need_swap;
  wire swap_pend = swap_req_q ^ swap_act_q;
  // swap applied only with no write in flight
  wire swap_apply = swap_pend & ~bus.busy & idle & ~go;
  // interrupt held off while swap change pends
  // the vector service issues reads only
  wire vec_start = bus.irq_req & irq_en_q & ~swap_pend & idle & ~go & ~irq_ack_q;
  // standby safe only with nothing in flight
  wire safe = idle & ~bus.busy;
  wire stat_clr_done = wr_fire & hit_stat & pwdata[STAT_DONE];
  wire stat_clr_err  = wr_fire & hit_stat & pwdata[STAT_ERR];

  always_comb begin
    rmux = 32'h0;
    if (hit_addr) rmux = {16'h0, addr_q};
    if (hit_wdat) rmux = {24'h0, wdata_q};
    if (hit_stat) rmux = {18'h0, bus.busy, safe, bus.irq_req, err_q, done_q, ~idle, rd_q};
    if (hit_cfg)  rmux = {27'h0, swap_act_q, lvl_q, irq_en_q, swap_req_q};
    if (hit_vec)  rmux = {16'h0, vec_q};
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
      prdata_q   <= '0;
      addr_q     <= '0;
      wdata_q    <= '0;
      swap_req_q <= 1'b0;
      irq_en_q   <= 1'b0;
      lvl_q      <= LVL_RST;
    end else begin
      pready_q  <= acc_new;
      pslverr_q <= acc_new & ~mapped;
      if (acc_new) prdata_q <= rmux;
      if (wr_fire & hit_addr) addr_q <= pwdata[15:0];
      if (wr_fire & hit_wdat) wdata_q <= pwdata[7:0];
      if (wr_fire & hit_cfg) begin
        swap_req_q <= pwdata[CFG_SWAP];
        irq_en_q   <= pwdata[CFG_IRQ_EN];
        lvl_q      <= pwdata[CFG_LVL_LSB +: 2];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q        <= HS_IDLE;
      req_q       <= 1'b0;
      op_q        <= FS_OP_READ;
      a_q         <= '0;
      exp_q       <= '0;
      rd_q        <= '0;
      vec_q       <= '0;
      vec_lo_q    <= 1'b0;
      idle_seen_q <= 1'b0;
      swap_act_q  <= 1'b0;
      irq_ack_q   <= 1'b0;
      done_q      <= 1'b0;
      err_q       <= 1'b0;
    end else begin
      irq_ack_q <= 1'b0;
      if (swap_apply) swap_act_q <= swap_req_q;
      // sticky flags, a new event wins over the clear
      if (stat_clr_done) done_q <= 1'b0;
      if (stat_clr_err) err_q <= 1'b0;
      if (go & ~go_ok) err_q <= 1'b1;
      case (st_q)
        HS_IDLE: begin
          if (go_ok) begin
            st_q        <= HS_CMD;
            req_q       <= 1'b1;
            op_q        <= new_op;
            a_q         <= addr_q;
            exp_q       <= (new_op == FS_OP_PROG) ? wdata_q : ERASED;
            idle_seen_q <= 1'b0;
          end else if (vec_start) begin
            st_q     <= HS_VEC;
            req_q    <= 1'b1;
            op_q     <= FS_OP_VEC;
            a_q      <= VEC_HI_ADDR;
            vec_lo_q <= 1'b0;
          end
        end
        HS_CMD: begin
          if (bus.ack) begin
            req_q <= 1'b0;
            rd_q  <= bus.rdata;
            if (bus.refused) begin
              st_q  <= HS_IDLE;
              err_q <= 1'b1;
            end else if (op_q == FS_OP_PROG || op_q == FS_OP_SERASE || op_q == FS_OP_CERASE) begin
              st_q <= HS_POLL;
              op_q <= FS_OP_READ;
            end else begin
              st_q   <= HS_IDLE;
              done_q <= 1'b1;
            end
          end
        end
        // completion seen through the data-polling bit
        HS_POLL: begin
          if (req_q & bus.ack) begin
            req_q <= 1'b0;
            rd_q  <= bus.rdata;
            if (bus.rdata[7] == exp_q[7]) begin
              st_q   <= HS_IDLE;
              done_q <= 1'b1;
            end else if (idle_seen_q) begin
              st_q  <= HS_IDLE;
              err_q <= 1'b1;
            end else begin
              idle_seen_q <= ~bus.busy;
            end
          end else if (!req_q) begin
            req_q <= 1'b1;
          end
        end
        HS_VEC: begin
          if (req_q & bus.ack) begin
            req_q <= 1'b0;
            if (!vec_lo_q) begin
              vec_q[15:8] <= bus.rdata;
              vec_lo_q    <= 1'b1;
              a_q         <= VEC_LO_ADDR;
            end else begin
              vec_q[7:0] <= bus.rdata;
              irq_ack_q  <= 1'b1;
              st_q       <= HS_IDLE;
            end
          end else if (!req_q) begin
            req_q <= 1'b1;
          end
        end
        default: begin
          st_q  <= HS_IDLE;
          req_q <= 1'b0;
        end
      endcase
    end
  end

  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign bus.req       = req_q;
  assign bus.op        = op_q;
  assign bus.addr      = a_q;
  assign bus.wdata     = wdata_q;
  assign bus.swap_en   = swap_act_q;
  assign bus.irq_ack   = irq_ack_q;
  assign bus.irq_level = lvl_q;
endmodule : fs_flash_host

// >>> rtl/fs_if.sv
// connection between the flash array end and the cpu-side controller end
`timescale 1ns/1ps
interface fs_if;
  import fs_pkg::*;
  logic        req;
  fs_op_e      op;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        swap_en;
  logic        irq_ack;
  logic [1:0]  irq_level;
  logic        ack;
  logic [7:0]  rdata;
  logic        refused;
  logic        busy;
  logic        irq_req;
  logic [1:0]  irq_prio;

  modport dev (
    input  req, op, addr, wdata, swap_en, irq_ack, irq_level,
    output ack, rdata, refused, busy, irq_req, irq_prio
  );
  modport host (
    output req, op, addr, wdata, swap_en, irq_ack, irq_level,
    input  ack, rdata, refused, busy, irq_req, irq_prio
  );
endinterface : fs_if

// >>> rtl/fs_pkg.sv
// shared constants and types for the dual-bank flash controller pair
package fs_pkg;
  // clock and operation times
  localparam int CLK_PERIOD_NS = 4;
  localparam int PROG_TIME_NS  = 40;
  localparam int ERASE_TIME_NS = 400;
  localparam int PROG_CYC      = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYC     = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // array geometry: one bit of bank plus eight bits of offset
  localparam int IDX_W     = 9;
  localparam int ARR_SIZE  = 512;
  localparam int SECT_SIZE = 256;
  localparam int CNT_W     = 10;

  localparam logic [15:0]      VEC_HI_ADDR = 16'hffcc;
  localparam logic [15:0]      VEC_LO_ADDR = 16'hffcd;
  localparam logic [IDX_W-1:0] PROT_IDX    = 9'h1fc;
  localparam logic [7:0]       PROT_CODE   = 8'h01;
  localparam logic [7:0]       ERASED      = 8'hff;

  typedef enum logic [2:0] {
    FS_OP_READ, FS_OP_VEC, FS_OP_PROG, FS_OP_SERASE, FS_OP_CERASE
  } fs_op_e;

  // controller register map, byte offsets
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_ADDR  = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STAT  = 8'h0c;
  localparam logic [7:0] REG_CFG   = 8'h10;
  localparam logic [7:0] REG_VEC   = 8'h14;

  // field positions
  localparam int CTRL_GO     = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int STAT_BUSY   = 8;
  localparam int STAT_DONE   = 9;
  localparam int STAT_ERR    = 10;
  localparam int STAT_IRQ    = 11;
  localparam int STAT_SAFE   = 12;
  localparam int STAT_DBUSY  = 13;
  localparam int CFG_SWAP    = 0;
  localparam int CFG_IRQ_EN  = 1;
  localparam int CFG_LVL_LSB = 2;
  localparam int CFG_SWAPACT = 4;

  // values after reset
  localparam logic [1:0] LVL_RST = 2'h3;
endpackage : fs_pkg
